//--- dpfi_pkg.sv
// shared constants, types and helpers of the dual pcm frame interface
`default_nettype none
package dpfi_pkg;
	localparam int CLK_MHZ = 50;
	localparam int T_POR_US = 20000;
	localparam int T_INIT_US = 150000;
	localparam int T_REINIT_US = 130000;
	localparam int CNT_W = 24;
	localparam logic [3:0] A_CTRL = 4'h0;
	localparam logic [3:0] A_STAT = 4'h4;
	localparam logic [3:0] A_TXD = 4'h8;
	localparam logic [3:0] A_RXD = 4'hc;
	localparam logic [4:0] SLOT_IDLE = 5'h10;
	localparam logic [4:0] SLOT_BITS = 5'h08;
	localparam logic [2:0] LAST_BIT = 3'h7;
	localparam logic [3:0] LONG_MIN = 4'h2;
	localparam logic [3:0] HI_MAX = 4'hf;
	localparam logic [7:0] ALAW_XOR = 8'h55;
	localparam logic [7:0] MULAW_XOR = 8'h7f;
	typedef enum logic [1:0] {
		FMT_SEP = 2'h0,
		FMT_MUX = 2'h1,
		FMT_GCI = 2'h2,
		FMT_IDL = 2'h3
	} dpfi_fmt_t;
	typedef enum logic [2:0] {
		ST_POR = 3'h1,
		ST_INIT = 3'h2,
		ST_RUN = 3'h4
	} dpfi_state_t;
	typedef struct packed {
		logic [4:0] rsvd;
		logic law;
		logic mute1;
		logic mute0;
		dpfi_fmt_t fmt;
		logic swap;
		logic ref_sel;
		logic pd_tone1;
		logic pd_tone0;
		logic pd_codec1;
		logic pd_codec0;
	} dpfi_ctrl_t;
	localparam dpfi_ctrl_t CTRL_RST = '0;
	typedef struct packed {
		logic halted;
		logic frame_long;
		logic [1:0] reinit;
		logic init_busy;
		logic por_busy;
	} dpfi_stat_t;
	// line code from sign/segment/step code and back (self-inverse)
	function automatic logic [7:0] dpfi_law_map(input logic [7:0] c, input logic mu);
		return c ^ (mu ? MULAW_XOR : ALAW_XOR);
	endfunction
endpackage
`default_nettype wire

//--- dpfi_sync.sv
// two-flop synchroniser for a group of foreign inputs
`default_nettype none
module dpfi_sync #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_q;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			meta_q <= '0;
			q <= '0;
		end else begin
			meta_q <= d;
			q <= meta_q;
		end
	end
endmodule
`default_nettype wire

//--- dpfi_slot_cnt.sv
// data bit counter of one time slot chain, idles at the top value
`default_nettype none
module dpfi_slot_cnt (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic halt,
	input wire logic start,
	input wire logic step,
	output logic [4:0] cnt
);
	import dpfi_pkg::*;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt <= SLOT_IDLE;
		end else if (halt) begin
			cnt <= SLOT_IDLE;
		end else if (start) begin
			cnt <= '0;
		end else if (step && cnt != SLOT_IDLE) begin
			cnt <= cnt + 5'h01;
		end
	end
endmodule
`default_nettype wire

//--- dpfi_top.sv
// dual pcm frame interface with avalon-mm register slave
`default_nettype none
module dpfi_top #(
	parameter int POR_CYC = dpfi_pkg::T_POR_US * dpfi_pkg::CLK_MHZ,
	parameter int INIT_CYC = dpfi_pkg::T_INIT_US * dpfi_pkg::CLK_MHZ,
	parameter int REINIT_CYC = dpfi_pkg::T_REINIT_US * dpfi_pkg::CLK_MHZ
) (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic bit_clk,
	input wire logic frame_sync_ch0,
	input wire logic frame_sync_ch1,
	input wire logic pcm_rx_in_ch0,
	input wire logic pcm_rx_in_ch1,
	input wire logic channel_mute_pin_ch0,
	input wire logic channel_mute_pin_ch1,
	input wire logic global_powerdown_pin,
	output logic pcm_tx_out_ch0,
	output logic pcm_tx_oe_b_ch0,
	output logic pcm_tx_out_ch1,
	output logic pcm_tx_oe_b_ch1,
	output logic pll_ref_sync,
	output logic [1:0] codec_halted,
	output logic [1:0] tone_decoder_halted,
	output logic [1:0] tx_gain_amplifier_pd
);
	import dpfi_pkg::*;

	logic [1:0] rst_q;
	logic rst_s_b;
	logic [7:0] pin_s;
	logic bclk_s, fs_s0, fs_s1, din_s0, din_s1, mute_s0, mute_s1, pd_s;
	logic bclk_prev_q, rise, fall;
	dpfi_ctrl_t ctrl_q;
	dpfi_state_t st_q;
	logic [CNT_W-1:0] up_cnt_q;
	logic [CNT_W-1:0] reinit_cnt0_q, reinit_cnt1_q;
	logic pd_codec0_prev_q, pd_codec1_prev_q;
	logic done_q;
	logic [1:0] fs_at_rise_q, pend_q;
	logic [3:0] hi_cnt_q;
	logic frame_long_q, phase_q, ref_fs, ref_at_rise;
	logic gci_idl, mux, halt, step, sample;
	logic [1:0] start;
	logic [4:0] cnt0, cnt1;
	logic act0, act1, ena0, ena1, rdy0, rdy1;
	logic [2:0] bit0, bit1;
	logic [7:0] tx_data0_q, tx_data1_q, rx_data0_q, rx_data1_q, sr0_q, sr1_q;
	logic [7:0] line0, line1;
	logic din0, din1;
	dpfi_stat_t stat;

	// reset released through two flops
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			rst_q <= 2'h0;
		end else begin
			rst_q <= {rst_q[0], 1'b1};
		end
	end
	assign rst_s_b = rst_q[1];

	dpfi_sync #(.W(8)) u_sync (
		.clk(sys_clk),
		.rst_b(rst_s_b),
		.d({bit_clk, frame_sync_ch0, frame_sync_ch1, pcm_rx_in_ch0, pcm_rx_in_ch1,
			channel_mute_pin_ch0, channel_mute_pin_ch1, global_powerdown_pin}),
		.q(pin_s)
	);
	assign {bclk_s, fs_s0, fs_s1, din_s0, din_s1, mute_s0, mute_s1, pd_s} = pin_s;

	always_ff @(posedge sys_clk or negedge rst_s_b) begin
		if (!rst_s_b) begin
			bclk_prev_q <= 1'b0;
		end else begin
			bclk_prev_q <= bclk_s;
		end
	end
	assign rise = bclk_s & ~bclk_prev_q;
	assign fall = ~bclk_s & bclk_prev_q;

	// register slave: one wait cycle, then the answer
	assign avs_waitrequest = (avs_read | avs_write) & ~done_q;
	always_ff @(posedge sys_clk or negedge rst_s_b) begin
		if (!rst_s_b) begin
			done_q <= 1'b0;
		end else begin
			done_q <= (avs_read | avs_write) & ~done_q;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_s_b) begin
		if (!rst_s_b) begin
			ctrl_q <= CTRL_RST;
			tx_data0_q <= '0;
			tx_data1_q <= '0;
		end else if (avs_write && done_q) begin
			if (avs_address == A_CTRL) begin
				if (avs_byteenable[0]) ctrl_q[7:0] <= avs_writedata[7:0];
				if (avs_byteenable[1]) ctrl_q[10:8] <= avs_writedata[10:8];
			end else if (avs_address == A_TXD) begin
				if (avs_byteenable[0]) tx_data0_q <= avs_writedata[7:0];
				if (avs_byteenable[1]) tx_data1_q <= avs_writedata[15:8];
			end
		end
	end

	assign stat = '{halted: pd_s, frame_long: frame_long_q,
		reinit: {reinit_cnt1_q != '0, reinit_cnt0_q != '0},
		init_busy: st_q != ST_RUN, por_busy: st_q == ST_POR};

	always_ff @(posedge sys_clk or negedge rst_s_b) begin
		if (!rst_s_b) begin
			avs_readdata <= '0;
		end else if (avs_read && !done_q) begin
			case (avs_address)
				A_CTRL: avs_readdata <= {16'h0000, ctrl_q};
				A_STAT: avs_readdata <= {26'h0, stat};
				A_TXD: avs_readdata <= {16'h0000, tx_data1_q, tx_data0_q};
				A_RXD: avs_readdata <= {16'h0000, rx_data1_q, rx_data0_q};
				default: avs_readdata <= '0;
			endcase
		end
	end

	// internal reset pulse, then codec initialisation
	always_ff @(posedge sys_clk or negedge rst_s_b) begin
		if (!rst_s_b) begin
			st_q <= ST_POR;
			up_cnt_q <= '0;
		end else begin
			case (st_q)
				ST_POR: begin
					up_cnt_q <= up_cnt_q + CNT_W'(1);
					if (up_cnt_q == CNT_W'(POR_CYC - 1)) st_q <= ST_INIT;
				end
				ST_INIT: begin
					up_cnt_q <= up_cnt_q + CNT_W'(1);
					if (up_cnt_q == CNT_W'(INIT_CYC - 1)) st_q <= ST_RUN;
				end
				ST_RUN: up_cnt_q <= up_cnt_q;
				default: st_q <= ST_POR;
			endcase
		end
	end

	// codec restart after block power-down ends
	always_ff @(posedge sys_clk or negedge rst_s_b) begin
		if (!rst_s_b) begin
			pd_codec0_prev_q <= 1'b0;
			pd_codec1_prev_q <= 1'b0;
			reinit_cnt0_q <= '0;
			reinit_cnt1_q <= '0;
		end else begin
			pd_codec0_prev_q <= ctrl_q.pd_codec0;
			pd_codec1_prev_q <= ctrl_q.pd_codec1;
			if (pd_codec0_prev_q && !ctrl_q.pd_codec0) begin
				reinit_cnt0_q <= CNT_W'(REINIT_CYC);
			end else if (reinit_cnt0_q != '0) begin
				reinit_cnt0_q <= reinit_cnt0_q - CNT_W'(1);
			end
			if (pd_codec1_prev_q && !ctrl_q.pd_codec1) begin
				reinit_cnt1_q <= CNT_W'(REINIT_CYC);
			end else if (reinit_cnt1_q != '0) begin
				reinit_cnt1_q <= reinit_cnt1_q - CNT_W'(1);
			end
		end
	end

	assign gci_idl = ctrl_q.fmt[1];
	assign mux = ctrl_q.fmt != FMT_SEP;
	assign ref_fs = (gci_idl || !ctrl_q.ref_sel) ? fs_s0 : fs_s1;
	assign ref_at_rise = (gci_idl || !ctrl_q.ref_sel) ? fs_at_rise_q[0] : fs_at_rise_q[1];
	assign halt = pd_s || st_q == ST_POR;

	// sync sampling, high-time measure, data-rate phase
	always_ff @(posedge sys_clk or negedge rst_s_b) begin
		if (!rst_s_b) begin
			fs_at_rise_q <= 2'h0;
			pend_q <= 2'h0;
			hi_cnt_q <= '0;
			frame_long_q <= 1'b1;
			phase_q <= 1'b0;
			pll_ref_sync <= 1'b0;
		end else begin
			pll_ref_sync <= ref_fs;
			if (rise) begin
				fs_at_rise_q <= {fs_s1, fs_s0};
				pend_q <= {fs_s1 & ~fs_at_rise_q[1], fs_s0 & ~fs_at_rise_q[0]} & {2{~frame_long_q}};
				if (ref_fs) begin
					hi_cnt_q <= (hi_cnt_q == HI_MAX) ? HI_MAX : hi_cnt_q + 4'h1;
				end else begin
					hi_cnt_q <= '0;
				end
				if (!ref_fs && ref_at_rise) frame_long_q <= hi_cnt_q >= LONG_MIN;
				phase_q <= (ctrl_q.fmt == FMT_GCI) && (start[0] || !phase_q);
			end
		end
	end

	// long frame starts on the sync edge, short frame one clock later
	assign start[0] = rise & (frame_long_q ? fs_s0 & ~fs_at_rise_q[0] : pend_q[0]);
	assign start[1] = rise & (frame_long_q ? fs_s1 & ~fs_at_rise_q[1] : pend_q[1]);
	assign step = rise & ~phase_q;
	assign sample = fall & ((ctrl_q.fmt == FMT_GCI) ? phase_q : 1'b1);

	dpfi_slot_cnt u_cnt0 (
		.clk(sys_clk),
		.rst_b(rst_s_b),
		.halt(halt),
		.start(start[0]),
		.step(step),
		.cnt(cnt0)
	);
	dpfi_slot_cnt u_cnt1 (
		.clk(sys_clk),
		.rst_b(rst_s_b),
		.halt(halt | gci_idl),
		.start(start[1]),
		.step(step),
		.cnt(cnt1)
	);

	// slot windows: own sync, or B1/B2 on sync 0 with swap
	always_comb begin
		if (gci_idl) begin
			act0 = !cnt0[4] && cnt0[3] == ctrl_q.swap;
			act1 = !cnt0[4] && cnt0[3] != ctrl_q.swap;
			bit0 = cnt0[2:0];
			bit1 = cnt0[2:0];
		end else begin
			act0 = cnt0 < SLOT_BITS;
			act1 = cnt1 < SLOT_BITS;
			bit0 = cnt0[2:0];
			bit1 = cnt1[2:0];
		end
	end

	assign rdy0 = st_q == ST_RUN && reinit_cnt0_q == '0 && !ctrl_q.pd_codec0 && !pd_s;
	assign rdy1 = st_q == ST_RUN && reinit_cnt1_q == '0 && !ctrl_q.pd_codec1 && !pd_s;
	assign ena0 = act0 && rdy0 && !mute_s0 && !ctrl_q.mute0;
	assign ena1 = act1 && rdy1 && !mute_s1 && !ctrl_q.mute1;
	assign line0 = dpfi_law_map(tx_data0_q, ctrl_q.law);
	assign line1 = dpfi_law_map(tx_data1_q, ctrl_q.law);
	assign din0 = din_s0;
	assign din1 = mux ? din_s0 : din_s1;

	// transmit pins, msb first, driven only inside the word
	always_ff @(posedge sys_clk or negedge rst_s_b) begin
		if (!rst_s_b) begin
			pcm_tx_out_ch0 <= 1'b0;
			pcm_tx_oe_b_ch0 <= 1'b1;
			pcm_tx_out_ch1 <= 1'b0;
			pcm_tx_oe_b_ch1 <= 1'b1;
		end else begin
			pcm_tx_oe_b_ch0 <= !(ena0 || (mux && ena1));
			pcm_tx_out_ch0 <= ena0 ? line0[LAST_BIT - bit0] : line1[LAST_BIT - bit1];
			pcm_tx_oe_b_ch1 <= !(ena1 && !mux);
			pcm_tx_out_ch1 <= line1[LAST_BIT - bit1];
		end
	end

	// receive shift, word stored after its last bit
	always_ff @(posedge sys_clk or negedge rst_s_b) begin
		if (!rst_s_b) begin
			sr0_q <= '0;
			sr1_q <= '0;
			rx_data0_q <= '0;
			rx_data1_q <= '0;
		end else if (sample) begin
			if (act0 && rdy0) begin
				sr0_q <= {sr0_q[6:0], din0};
				if (bit0 == LAST_BIT) rx_data0_q <= dpfi_law_map({sr0_q[6:0], din0}, ctrl_q.law);
			end
			if (act1 && rdy1) begin
				sr1_q <= {sr1_q[6:0], din1};
				if (bit1 == LAST_BIT) rx_data1_q <= dpfi_law_map({sr1_q[6:0], din1}, ctrl_q.law);
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_s_b) begin
		if (!rst_s_b) begin
			codec_halted <= 2'h3;
			tone_decoder_halted <= 2'h3;
			tx_gain_amplifier_pd <= 2'h3;
		end else begin
			codec_halted <= {!rdy1, !rdy0};
			tone_decoder_halted <= {ctrl_q.pd_tone1 | pd_s, ctrl_q.pd_tone0 | pd_s};
			tx_gain_amplifier_pd <= {ctrl_q.pd_codec1 & ctrl_q.pd_tone1,
				ctrl_q.pd_codec0 & ctrl_q.pd_tone0};
		end
	end

	pin1_mux_a: assert property (@(posedge sys_clk) disable iff (!rst_s_b)
		!pcm_tx_oe_b_ch1 |-> $past(ctrl_q.fmt) == FMT_SEP)
		else $error("channel 1 pin driven in a multiplexed format");
	ref_select_a: assert property (@(posedge sys_clk) disable iff (!rst_s_b)
		gci_idl |=> pll_ref_sync == $past(fs_s0))
		else $error("reference sync not taken from sync 0");
	frame_type_a: assert property (@(posedge sys_clk) disable iff (!rst_s_b)
		(rise && !ref_fs && ref_at_rise && hi_cnt_q >= LONG_MIN) |=> frame_long_q)
		else $error("long frame not detected");
	mute_pin_a: assert property (@(posedge sys_clk) disable iff (!rst_s_b)
		(mute_s0 && !mux) |=> pcm_tx_oe_b_ch0)
		else $error("muted channel 0 still drives");
	por_hiz_a: assert property (@(posedge sys_clk) disable iff (!rst_s_b)
		st_q == ST_POR |=> pcm_tx_oe_b_ch0 && pcm_tx_oe_b_ch1)
		else $error("pin driven during power-on pulse");
	global_pd_a: assert property (@(posedge sys_clk) disable iff (!rst_s_b)
		pd_s |=> cnt0 == SLOT_IDLE && pcm_tx_oe_b_ch0 && pcm_tx_oe_b_ch1)
		else $error("activity during global power-down");
	amp_pd_a: assert property (@(posedge sys_clk) disable iff (!rst_s_b)
		(ctrl_q.pd_codec0 && ctrl_q.pd_tone0) |=> tx_gain_amplifier_pd[0])
		else $error("tx amplifier 0 not powered down");
	reinit_a: assert property (@(posedge sys_clk) disable iff (!rst_s_b)
		$fell(pd_codec0_prev_q) |-> reinit_cnt0_q != '0 ##1 codec_halted[0])
		else $error("codec 0 not reinitialised");
	tx_window_a: assert property (@(posedge sys_clk) disable iff (!rst_s_b)
		!pcm_tx_oe_b_ch0 |-> $past(act0) || $past(act1))
		else $error("channel 0 pin driven outside a slot");
endmodule
`default_nettype wire

//--- dpfi_pcm_far.sv
// far-end pcm highway model: bit clock, syncs, receive data, transmit capture
`default_nettype none
module dpfi_pcm_far (
	output logic bit_clk,
	output logic fs0,
	output logic fs1,
	output logic rx0,
	output logic rx1,
	input wire logic tx0,
	input wire logic oe0_b,
	input wire logic tx1,
	input wire logic oe1_b,
	input wire dpfi_pkg::dpfi_fmt_t fmt,
	input wire logic swap,
	input wire logic lng,
	input wire logic [1:0] sb,
	input wire logic [7:0] rw0,
	input wire logic [7:0] rw1,
	output logic [31:0] cap0,
	output logic [31:0] cap1,
	output logic [5:0] n0,
	output logic [5:0] n1
);
	timeunit 1ns;
	timeprecision 1ps;
	import dpfi_pkg::*;
	logic [4:0] bc = '0;
	logic [4:0] d, st, dd;
	logic [31:0] s0 = '0, s1 = '0;
	logic [5:0] c0 = '0, c1 = '0;
	logic ina, inb, cha;
	logic [7:0] wa, wb;
	initial begin
		bit_clk = 1'b0;
		#7;
		forever #80 bit_clk = ~bit_clk;
	end
	// frame shortened to 32 bit clocks
	always @(negedge bit_clk) bc <= bc + 5'h01;
	always_comb begin
		d = (fmt == FMT_GCI) ? {1'b0, bc[4:1]} : bc;
		st = fmt[1] ? 5'h08 : {sb, 3'h0};
		dd = d - st;
		ina = d < 5'h08;
		inb = d >= st && dd < 5'h08;
		cha = fmt[1] & swap;
		wa = cha ? rw1 : rw0;
		wb = cha ? rw0 : rw1;
	end
	assign fs0 = lng ? bc < 5'h03 : bc == 5'h1f;
	assign fs1 = fmt[1] ? 1'b0 : lng ? (bc >= st && bc - st < 5'h03) : bc == st - 5'h01;
	// launched on the rise, so the fall sample sees a settled bit
	// released data lines toggle every bit, except rx1 in the multiplexed formats, which is held low
	always @(posedge bit_clk) begin
		rx0 <= ina ? wa[~d[2:0]] : (fmt != FMT_SEP && inb) ? wb[~dd[2:0]] : bc[0];
		rx1 <= fmt != FMT_SEP ? 1'b0 : inb ? wb[~dd[2:0]] : bc[0];
	end
	// transmit sampled at each rise, frame closed at count 0
	always @(posedge bit_clk) begin
		s0 = oe0_b ? s0 : {s0[30:0], tx0};
		s1 = oe1_b ? s1 : {s1[30:0], tx1};
		c0 = c0 + 6'(!oe0_b);
		c1 = c1 + 6'(!oe1_b);
		if (bc == 5'h00) begin
			{cap0, cap1, n0, n1} <= {s0, s1, c0, c1};
			{s0, s1, c0, c1} = '0;
		end
	end
endmodule
`default_nettype wire

//--- dpfi_top_bench.sv
// self-checking bench of the dual pcm frame interface
`default_nettype none
module dpfi_top_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import dpfi_pkg::*;
	typedef struct packed {
		dpfi_fmt_t fmt;
		logic swap;
		logic law;
		logic lng;
		logic rsel;
		logic [1:0] sb;
		logic [5:0] n0;
		logic [5:0] n1;
	} dpfi_row_t;
	localparam int REI = 100;
	localparam dpfi_row_t ROWS [8] = '{
		'{FMT_SEP, 1'b0, 1'b0, 1'b1, 1'b0, 2'h2, 6'h08, 6'h08},
		'{FMT_SEP, 1'b0, 1'b1, 1'b0, 1'b1, 2'h2, 6'h08, 6'h08},
		'{FMT_MUX, 1'b0, 1'b0, 1'b1, 1'b0, 2'h1, 6'h10, 6'h00},
		'{FMT_MUX, 1'b0, 1'b1, 1'b0, 1'b1, 2'h3, 6'h10, 6'h00},
		'{FMT_GCI, 1'b0, 1'b0, 1'b1, 1'b0, 2'h1, 6'h20, 6'h00},
		'{FMT_GCI, 1'b1, 1'b1, 1'b1, 1'b0, 2'h1, 6'h20, 6'h00},
		'{FMT_IDL, 1'b0, 1'b0, 1'b1, 1'b0, 2'h1, 6'h10, 6'h00},
		'{FMT_IDL, 1'b1, 1'b1, 1'b1, 1'b1, 2'h1, 6'h10, 6'h00}
	};
	logic sys_clk = 1'b0;
	logic rst_b = 1'b0;
	logic [3:0] avs_address = '0;
	logic avs_read = 1'b0, avs_write = 1'b0;
	logic [31:0] avs_writedata = '0, avs_readdata, rd, cap0, cap1;
	logic [3:0] avs_byteenable = 4'h3;
	logic avs_waitrequest, bit_clk, fs0, fs1, rx0, rx1, tx0, oe0_b, tx1, oe1_b, pll_ref_sync;
	logic mute0 = 1'b0, mute1 = 1'b0, gpd = 1'b0, swap = 1'b0, lng = 1'b1;
	logic [1:0] codec_halted, tone_halted, amp_pd, sb = 2'h2;
	dpfi_fmt_t fmt = FMT_SEP;
	logic [7:0] rw0 = '0, rw1 = '0;
	logic [5:0] n0, n1;
	int errors = 0, check_count = 0;
	dpfi_top #(.POR_CYC(50), .INIT_CYC(200), .REINIT_CYC(REI)) dpfi_top_i (
		.sys_clk(sys_clk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .bit_clk(bit_clk),
		.frame_sync_ch0(fs0), .frame_sync_ch1(fs1), .pcm_rx_in_ch0(rx0), .pcm_rx_in_ch1(rx1),
		.channel_mute_pin_ch0(mute0), .channel_mute_pin_ch1(mute1),
		.global_powerdown_pin(gpd), .pcm_tx_out_ch0(tx0), .pcm_tx_oe_b_ch0(oe0_b),
		.pcm_tx_out_ch1(tx1), .pcm_tx_oe_b_ch1(oe1_b), .pll_ref_sync(pll_ref_sync),
		.codec_halted(codec_halted), .tone_decoder_halted(tone_halted),
		.tx_gain_amplifier_pd(amp_pd));
	dpfi_pcm_far dpfi_pcm_far_i (
		.bit_clk(bit_clk), .fs0(fs0), .fs1(fs1), .rx0(rx0), .rx1(rx1), .tx0(tx0),
		.oe0_b(oe0_b), .tx1(tx1), .oe1_b(oe1_b), .fmt(fmt), .swap(swap), .lng(lng), .sb(sb),
		.rw0(rw0), .rw1(rw1), .cap0(cap0), .cap1(cap1), .n0(n0), .n1(n1));
	initial begin
		forever #10 sys_clk = ~sys_clk;
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
		avs_address <= a;
		avs_writedata <= wd;
		avs_write <= wr;
		avs_read <= !wr;
		do begin
			@(posedge sys_clk);
		end while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		// idle edge between requests
		@(posedge sys_clk);
	endtask
	task automatic frames(input int k);
		repeat (k) @(posedge fs0);
		repeat (2) @(posedge bit_clk);
		@(posedge sys_clk);
	endtask
	function automatic logic [15:0] dup(input logic [7:0] w);
		for (int j = 0; j < 8; j++) dup[2*j +: 2] = {2{w[j]}};
	endfunction
	task automatic close_out;
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	initial begin
		#1000000;
		errors++;
		close_out;
	end
	initial begin
		dpfi_row_t r;
		logic [7:0] x, c0, c1, wa, wb, k;
		repeat (10) @(posedge sys_clk);
		chk({oe1_b, oe0_b, codec_halted, tone_halted, amp_pd}, 32'hff);
		rst_b <= 1'b1;
		repeat (3) @(posedge sys_clk);
		bus(1'b0, A_STAT, '0);
		chk({oe1_b, oe0_b, rd[1:0]}, 32'hf);
		repeat (60) @(posedge sys_clk);
		bus(1'b0, A_STAT, '0);
		chk({codec_halted, rd[1:0]}, 32'he);
		repeat (220) @(posedge sys_clk);
		bus(1'b0, A_STAT, '0);
		chk({codec_halted, rd[1:0]}, 32'h0);
		bus(1'b0, A_CTRL, '0);
		chk(rd, 32'h0);
		bus(1'b1, 4'h2, 32'hffff);
		bus(1'b0, 4'h2, '0);
		chk(rd, 32'h0);
		for (int i = 0; i < 8; i++) begin
			r = ROWS[i];
			k = 8'(i);
			c0 = 8'ha3 ^ k;
			c1 = 8'h5c + k;
			x = r.law ? MULAW_XOR : ALAW_XOR;
			fmt = r.fmt;
			{swap, lng, sb, rw0, rw1} = {r.swap, r.lng, r.sb, 8'h3e ^ k, 8'hd1 - k};
			bus(1'b1, A_CTRL, {21'h0, r.law, 2'h0, r.fmt, r.swap, r.rsel, 4'h0});
			bus(1'b1, A_TXD, {16'h0, c1, c0});
			frames(4);
			wa = (r.fmt[1] & r.swap ? c1 : c0) ^ x;
			wb = (r.fmt[1] & r.swap ? c0 : c1) ^ x;
			chk(cap0, r.fmt == FMT_SEP ? {24'h0, wa} :
				r.fmt == FMT_GCI ? {dup(wa), dup(wb)} : {16'h0, wa, wb});
			chk(cap1, r.fmt == FMT_SEP ? {24'h0, wb} : 32'h0);
			chk({n1, n0}, {r.n1, r.n0});
			bus(1'b0, A_RXD, '0);
			chk(rd[15:0], {rw1 ^ x, rw0 ^ x});
			bus(1'b0, A_STAT, '0);
			chk(rd[4], r.lng);
			if (r.fmt[1]) @(posedge fs0);
			else @(posedge fs1);
			repeat (6) @(posedge sys_clk);
			chk(pll_ref_sync, r.fmt[1] | r.rsel);
		end
		fmt = FMT_SEP;
		{lng, sb} = {1'b1, 2'h2};
		bus(1'b1, A_CTRL, 32'h0);
		mute0 <= 1'b1;
		frames(4);
		chk({n1, n0}, {6'h08, 6'h00});
		mute0 <= 1'b0;
		bus(1'b1, A_CTRL, 32'h200);
		frames(4);
		chk({n1, n0}, {6'h00, 6'h08});
		bus(1'b1, A_CTRL, 32'h5);
		frames(3);
		chk({codec_halted, tone_halted, amp_pd, n0}, {6'h15, 6'h0});
		bus(1'b1, A_CTRL, 32'h1);
		repeat (3) @(posedge sys_clk);
		chk(amp_pd, 32'h0);
		bus(1'b1, A_CTRL, 32'h0);
		repeat (3) @(posedge sys_clk);
		bus(1'b0, A_STAT, '0);
		chk({rd[3:2], codec_halted}, 32'h5);
		repeat (REI + 20) @(posedge sys_clk);
		bus(1'b0, A_STAT, '0);
		chk({rd[3:2], codec_halted}, 32'h0);
		bus(1'b1, A_CTRL, 32'h10);
		gpd <= 1'b1;
		frames(3);
		chk({tone_halted, n0}, {2'h3, 6'h0});
		bus(1'b0, A_CTRL, '0);
		chk(rd, 32'h10);
		bus(1'b0, A_STAT, '0);
		chk(rd[5], 1'b1);
		gpd <= 1'b0;
		close_out;
	end
endmodule
`default_nettype wire
